//--- prsu_pkg.sv
package prsu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int STACK_DEPTH = 31;
    localparam int PC_W = 21;
    localparam int PTR_W = 5;
    localparam int LATU_W = 5;
    localparam int OFS_W = 11;
    localparam int TGT_W = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and program counter values
    localparam logic [4:0] PTR_EMPTY = 5'h00;
    localparam logic [4:0] PTR_ONE = 5'h01;
    localparam logic [4:0] PTR_LAST_FREE = 5'h1E;
    localparam logic [4:0] PTR_FULL = 5'h1F;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] ENTRY_ZERO = 21'h000000;
    localparam logic [15:0] INSTR_NOP = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] PAD_UPPER = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Special-function register addresses
    localparam logic [11:0] ADDR_TOP_UPPER = 12'hFFF;
    localparam logic [11:0] ADDR_TOP_HIGH = 12'hFFE;
    localparam logic [11:0] ADDR_TOP_LOW = 12'hFFD;
    localparam logic [11:0] ADDR_POINTER = 12'hFFC;
    localparam logic [11:0] ADDR_PC_ULATCH = 12'hFFB;
    localparam logic [11:0] ADDR_PC_HLATCH = 12'hFFA;
    localparam logic [11:0] ADDR_PC_LOW = 12'hFF9;

    ////////////////////////////////////////////////////////////////////////////
    // Pointer register layout
    localparam int OVF_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int PTR_MSB = 4;
    localparam logic PTR_PAD = 1'b0;

    // Byte lanes of a stack entry
    localparam int LANE_LOW = 0;
    localparam int LANE_HIGH = 1;
    localparam int LANE_UPPER = 2;
    localparam logic [2:0] MASK_ALL = 3'h7;
    localparam logic [2:0] MASK_NONE = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} prsu_phase_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_CALL, OP_RELATIVE_CALL, OP_JUMP, OP_BRANCH, OP_RETURN,
        OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_PUSH, OP_POP, OP_INTACK
    } prsu_op_t;

    typedef struct packed {
        prsu_op_t op;
        logic fast;
        logic [19:0] target;
        logic [10:0] offset;
    } prsu_cmd_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } prsu_sfr_req_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } prsu_shadow_t;

endpackage : prsu_pkg

//--- prsu_phase_gen.sv
`timescale 1ns/1ns
module prsu_phase_gen (
    input wire logic mclk,
    input wire logic rstn,
    output logic q1,
    output logic q2,
    output logic q3,
    output logic q4
);

    prsu_pkg::prsu_phase_t phase;

    ////////////////////////////////////////////////////////////////////////////
    // Divide by four into four enables
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase <= prsu_pkg::PH_Q1;
        end else begin
            case (phase)
                prsu_pkg::PH_Q1: phase <= prsu_pkg::PH_Q2;
                prsu_pkg::PH_Q2: phase <= prsu_pkg::PH_Q3;
                prsu_pkg::PH_Q3: phase <= prsu_pkg::PH_Q4;
                prsu_pkg::PH_Q4: phase <= prsu_pkg::PH_Q1;
                default: phase <= prsu_pkg::PH_Q1;
            endcase
        end
    end

    assign q1 = (phase == prsu_pkg::PH_Q1);
    assign q2 = (phase == prsu_pkg::PH_Q2);
    assign q3 = (phase == prsu_pkg::PH_Q3);
    assign q4 = (phase == prsu_pkg::PH_Q4);

    a_phase_order: assert property (@(posedge mclk) disable iff (!rstn) q1 |=> q2 ##1 q3 ##1 q4 ##1 q1)
        else $error("phase order broken");

endmodule : prsu_phase_gen

//--- prsu_stack_ram.sv
`timescale 1ns/1ns
module prsu_stack_ram (
    input wire logic mclk,
    input wire logic [2:0] wrMask,
    input wire logic [4:0] wrAddr,
    input wire logic [20:0] wrData,
    input wire logic [4:0] rdAddr,
    output logic [20:0] rdData
);

    // Index zero has no storage: it is only the empty state
    logic [20:0] entry [1:31];

    always_ff @(posedge mclk) begin
        if (wrAddr != prsu_pkg::PTR_EMPTY) begin
            if (wrMask[prsu_pkg::LANE_LOW]) begin
                entry[wrAddr][7:0] <= wrData[7:0];
            end
            if (wrMask[prsu_pkg::LANE_HIGH]) begin
                entry[wrAddr][15:8] <= wrData[15:8];
            end
            if (wrMask[prsu_pkg::LANE_UPPER]) begin
                entry[wrAddr][20:16] <= wrData[20:16];
            end
        end
    end

    assign rdData = (rdAddr == prsu_pkg::PTR_EMPTY) ? prsu_pkg::ENTRY_ZERO : entry[rdAddr];

endmodule : prsu_stack_ram

//--- prsu_core.sv
`timescale 1ns/1ns
module prsu_core (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic softRst,
    input wire logic stack_fault_reset_enable,
    input wire logic cmdValid,
    input wire prsu_pkg::prsu_cmd_t cmd,
    output logic cmdReady,
    input wire prsu_pkg::prsu_sfr_req_t sfrReq,
    output logic [7:0] sfrRdata,
    input wire prsu_pkg::prsu_shadow_t liveRegs,
    output prsu_pkg::prsu_shadow_t shadowOut,
    output logic shadowRestore,
    input wire logic [15:0] instrIn,
    output logic [20:0] fetchAddr,
    output logic [15:0] instrReg,
    output logic flushActive,
    output logic operandRead,
    output logic resultWrite,
    output logic deviceResetReq
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic pushesPc(input prsu_pkg::prsu_op_t op);
        pushesPc = (op == prsu_pkg::OP_CALL) || (op == prsu_pkg::OP_RELATIVE_CALL) ||
                   (op == prsu_pkg::OP_INTACK) || (op == prsu_pkg::OP_PUSH);
    endfunction : pushesPc

    function automatic logic popsPc(input prsu_pkg::prsu_op_t op);
        popsPc = (op == prsu_pkg::OP_RETURN) || (op == prsu_pkg::OP_RETURN_WITH_LITERAL) ||
                 (op == prsu_pkg::OP_RETURN_FROM_INTERRUPT);
    endfunction : popsPc

    function automatic logic changesPc(input prsu_pkg::prsu_op_t op);
        changesPc = popsPc(op) || (op == prsu_pkg::OP_CALL) || (op == prsu_pkg::OP_RELATIVE_CALL) ||
                    (op == prsu_pkg::OP_JUMP) || (op == prsu_pkg::OP_BRANCH) ||
                    (op == prsu_pkg::OP_INTACK);
    endfunction : changesPc

    function automatic logic sfrHit(input prsu_pkg::prsu_sfr_req_t req, input logic [11:0] addr);
        sfrHit = (req.addr == addr);
    endfunction : sfrHit

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic q1;
    logic q2;
    logic q3;
    logic q4;
    logic [4:0] pointer_bits;
    logic overflow_flag;
    logic underflow_flag;
    logic [20:0] pc;
    logic [7:0] pc_high_latch;
    logic [4:0] pc_upper_latch;
    logic [20:0] stack_top;
    logic [2:0] ramMask;
    logic [4:0] ramAddr;
    logic [20:0] ramData;

    logic take;
    logic isPush;
    logic isPop;
    logic isDiscard;
    logic pcChange;
    logic atEmpty;
    logic atFull;
    logic fullPush;
    logic emptyPop;
    logic faultRst;
    logic anyRst;
    logic pclWr;
    logic pclRd;
    logic ptrWr;
    logic flushStart;
    logic [20:0] branchTarget;
    logic [20:0] pushValue;

    prsu_phase_gen u_phase (
        .mclk(mclk),
        .rstn(rstn),
        .q1(q1),
        .q2(q2),
        .q3(q3),
        .q4(q4)
    );

    prsu_stack_ram u_ram (
        .mclk(mclk),
        .wrMask(ramMask),
        .wrAddr(ramAddr),
        .wrData(ramData),
        .rdAddr(pointer_bits),
        .rdData(stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command acceptance; one command per instruction cycle, taken at Q4
    assign cmdReady = q4 && !flushActive;
    assign take = cmdValid && cmdReady;
    assign isPush = take && pushesPc(cmd.op);
    assign isPop = take && popsPc(cmd.op);
    assign isDiscard = take && (cmd.op == prsu_pkg::OP_POP);
    assign pcChange = take && changesPc(cmd.op);
    assign atEmpty = (pointer_bits == prsu_pkg::PTR_EMPTY);
    assign atFull = (pointer_bits == prsu_pkg::PTR_FULL);
    // The 31st push, or any push once saturated
    assign fullPush = isPush && ((pointer_bits == prsu_pkg::PTR_LAST_FREE) || atFull);
    assign emptyPop = (isPop || isDiscard) && atEmpty;
    assign faultRst = stack_fault_reset_enable && (fullPush || emptyPop);
    assign anyRst = softRst || faultRst;

    // Bus accesses to own registers; pointer write yields to a stack command
    assign pclWr = sfrReq.wr && sfrHit(sfrReq, prsu_pkg::ADDR_PC_LOW);
    assign pclRd = sfrReq.rd && sfrHit(sfrReq, prsu_pkg::ADDR_PC_LOW);
    assign ptrWr = sfrReq.wr && sfrHit(sfrReq, prsu_pkg::ADDR_POINTER);
    assign flushStart = pcChange || pclWr;

    assign branchTarget = pc + 21'({{(prsu_pkg::TGT_W - prsu_pkg::OFS_W){cmd.offset[10]}}, cmd.offset, 1'b0});
    assign pushValue = faultRst ? (pc + prsu_pkg::PC_STEP) : pc;

    ////////////////////////////////////////////////////////////////////////////
    // Stack entry writes
    always_comb begin
        ramMask = prsu_pkg::MASK_NONE;
        ramAddr = pointer_bits;
        ramData = pushValue;
        if (isPush && !atFull) begin
            ramMask = prsu_pkg::MASK_ALL;
            ramAddr = pointer_bits + prsu_pkg::PTR_ONE;
        end else if (sfrReq.wr && !atEmpty) begin
            ramData = {sfrReq.wdata[4:0], sfrReq.wdata, sfrReq.wdata};
            ramMask[prsu_pkg::LANE_UPPER] = sfrHit(sfrReq, prsu_pkg::ADDR_TOP_UPPER);
            ramMask[prsu_pkg::LANE_HIGH] = sfrHit(sfrReq, prsu_pkg::ADDR_TOP_HIGH);
            ramMask[prsu_pkg::LANE_LOW] = sfrHit(sfrReq, prsu_pkg::ADDR_TOP_LOW);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pointer_bits <= prsu_pkg::PTR_EMPTY;
        end else if (anyRst) begin
            pointer_bits <= prsu_pkg::PTR_EMPTY;
        end else if (isPush) begin
            if (!atFull) begin
                pointer_bits <= pointer_bits + prsu_pkg::PTR_ONE;
            end
        end else if (isPop || isDiscard) begin
            if (!atEmpty) begin
                pointer_bits <= pointer_bits - prsu_pkg::PTR_ONE;
            end
        end else if (ptrWr) begin
            pointer_bits <= sfrReq.wdata[prsu_pkg::PTR_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: set wins over a software clear; of the resets, only a power-on reset clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            overflow_flag <= 1'b0;
            underflow_flag <= 1'b0;
        end else begin
            overflow_flag <= fullPush || (overflow_flag && !(ptrWr && !sfrReq.wdata[prsu_pkg::OVF_BIT]));
            underflow_flag <= emptyPop || (underflow_flag && !(ptrWr && !sfrReq.wdata[prsu_pkg::UNF_BIT]));
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            deviceResetReq <= 1'b0;
        end else begin
            deviceResetReq <= faultRst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc <= prsu_pkg::PC_RESET;
        end else if (anyRst) begin
            pc <= prsu_pkg::PC_RESET;
        end else if (pcChange) begin
            case (cmd.op)
                prsu_pkg::OP_CALL, prsu_pkg::OP_JUMP, prsu_pkg::OP_INTACK: begin
                    pc <= {cmd.target, 1'b0};
                end
                prsu_pkg::OP_RELATIVE_CALL, prsu_pkg::OP_BRANCH: begin
                    pc <= branchTarget;
                end
                prsu_pkg::OP_RETURN, prsu_pkg::OP_RETURN_WITH_LITERAL, prsu_pkg::OP_RETURN_FROM_INTERRUPT: begin
                    pc <= {stack_top[20:1], 1'b0};
                end
                default: begin
                    pc <= pc;
                end
            endcase
        end else if (pclWr) begin
            pc <= {pc_upper_latch, pc_high_latch, sfrReq.wdata[7:1], 1'b0};
        end else if (q1 && !flushActive) begin
            pc <= pc + prsu_pkg::PC_STEP;
        end
    end

    assign fetchAddr = pc;

    // Latches change only by their own writes or a low-byte read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc_high_latch <= prsu_pkg::BYTE_ZERO;
            pc_upper_latch <= prsu_pkg::PTR_EMPTY;
        end else if (pclRd) begin
            pc_high_latch <= pc[15:8];
            pc_upper_latch <= pc[20:16];
        end else if (sfrReq.wr) begin
            if (sfrHit(sfrReq, prsu_pkg::ADDR_PC_HLATCH)) begin
                pc_high_latch <= sfrReq.wdata;
            end
            if (sfrHit(sfrReq, prsu_pkg::ADDR_PC_ULATCH)) begin
                pc_upper_latch <= sfrReq.wdata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline: fetched word is replaced by a no-op after a PC change
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flushActive <= 1'b0;
            instrReg <= prsu_pkg::INSTR_NOP;
        end else if (softRst) begin
            flushActive <= 1'b0;
            instrReg <= prsu_pkg::INSTR_NOP;
        end else if (q4) begin
            flushActive <= flushStart;
            instrReg <= flushStart ? prsu_pkg::INSTR_NOP : instrIn;
        end else if (flushStart) begin
            flushActive <= 1'b1;
        end
    end

    assign operandRead = q2 && !flushActive;
    assign resultWrite = q4 && !flushActive;

    ////////////////////////////////////////////////////////////////////////////
    // Fast shadow; a later load simply overwrites the earlier one
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shadowOut <= '0;
            shadowRestore <= 1'b0;
        end else begin
            if (take && ((cmd.op == prsu_pkg::OP_INTACK) || (cmd.op == prsu_pkg::OP_CALL && cmd.fast))) begin
                shadowOut <= liveRegs;
            end
            shadowRestore <= isPop && cmd.fast && (cmd.op != prsu_pkg::OP_RETURN_WITH_LITERAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read data, one cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sfrRdata <= prsu_pkg::BYTE_ZERO;
        end else if (sfrReq.rd) begin
            case (sfrReq.addr)
                prsu_pkg::ADDR_TOP_UPPER: sfrRdata <= {prsu_pkg::PAD_UPPER, stack_top[20:16]};
                prsu_pkg::ADDR_TOP_HIGH: sfrRdata <= stack_top[15:8];
                prsu_pkg::ADDR_TOP_LOW: sfrRdata <= stack_top[7:0];
                prsu_pkg::ADDR_POINTER: sfrRdata <= {overflow_flag, underflow_flag, prsu_pkg::PTR_PAD, pointer_bits};
                prsu_pkg::ADDR_PC_ULATCH: sfrRdata <= {prsu_pkg::PAD_UPPER, pc_upper_latch};
                prsu_pkg::ADDR_PC_HLATCH: sfrRdata <= pc_high_latch;
                prsu_pkg::ADDR_PC_LOW: sfrRdata <= pc[7:0];
                default: sfrRdata <= prsu_pkg::BYTE_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_push_increments: assert property (isPush && !softRst && pointer_bits < prsu_pkg::PTR_LAST_FREE |=> pointer_bits == 5'($past(pointer_bits) + prsu_pkg::PTR_ONE))
        else $error("push did not increment pointer");
    a_pop_decrements: assert property (isPop && !softRst && !atEmpty ##1 1'b1 |-> pointer_bits == 5'($past(pointer_bits) - prsu_pkg::PTR_ONE) && pc == {$past(stack_top[20:1]), 1'b0})
        else $error("pop did not load PC and decrement");
    a_full_flag: assert property (isPush && pointer_bits == prsu_pkg::PTR_LAST_FREE |=> overflow_flag)
        else $error("overflow flag not set on 31st push");
    a_fault_reset: assert property (faultRst |=> pointer_bits == prsu_pkg::PTR_EMPTY && pc == prsu_pkg::PC_RESET && deviceResetReq)
        else $error("fault reset incomplete");
    a_full_saturate: assert property (isPush && atFull && !stack_fault_reset_enable && !softRst |=> atFull && overflow_flag)
        else $error("pointer moved past full");
    a_underflow_pop: assert property (isPop && atEmpty && !softRst |=> pc == prsu_pkg::PC_RESET && underflow_flag && atEmpty)
        else $error("underflow pop misbehaved");
    a_pc_even: assert property (pc[0] == 1'b0)
        else $error("PC bit 0 set");
    a_seq_step: assert property (q1 && !flushActive && !anyRst && !pcChange && !pclWr |=> pc == 21'($past(pc) + prsu_pkg::PC_STEP))
        else $error("sequential PC step wrong");
    a_flush_cycle: assert property (pcChange && !softRst |=> flushActive [*4] ##1 !flushActive || flushStart)
        else $error("flush cycle length wrong");
    a_latch_kept: assert property (pcChange && !sfrReq.wr && !pclRd |=> $stable(pc_high_latch) && $stable(pc_upper_latch))
        else $error("latches changed by call or return");
    a_shadow_load: assert property (take && cmd.op == prsu_pkg::OP_INTACK |=> shadowOut == $past(liveRegs))
        else $error("shadow not loaded on interrupt");
    a_pointer_read: assert property (sfrReq.rd && sfrReq.addr == prsu_pkg::ADDR_POINTER |=> sfrRdata[5] == 1'b0 && sfrRdata[4:0] == $past(pointer_bits))
        else $error("pointer register read wrong");

    c_call_return: cover property (isPush ##[1:40] isPop);
    c_full_stack: cover property (fullPush && !stack_fault_reset_enable);
    c_underflow: cover property (emptyPop);
    c_computed_jump: cover property (pclRd ##[1:20] pclWr);

endmodule : prsu_core

//--- prsu_decoder_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module prsu_decoder_model (
    input wire logic [20:0] fetchAddr,
    output logic [15:0] instrIn,
    output prsu_pkg::prsu_shadow_t liveRegs
);
    // Word tied to its address so a wrong fetch shows in the instruction register
    assign instrIn = fetchAddr[16:1] ^ 16'hA5C3;
    assign liveRegs = '{status: 8'h1C, working: 8'h5A, bank: 8'h0E};
endmodule : prsu_decoder_model

//--- prsu_core_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module prsu_core_tb;
    logic mclk, rstn, softRst, fault, cmdValid, cmdReady, shadowRestore, flushActive, operandRead, resultWrite, devRst;
    prsu_pkg::prsu_cmd_t cmd;
    prsu_pkg::prsu_sfr_req_t sfrReq;
    prsu_pkg::prsu_shadow_t liveRegs, shadowOut;
    logic [7:0] sfrRdata, d;
    logic [15:0] instrIn, instrReg;
    logic [20:0] fetchAddr, pcTake;
    logic [10:0] ofs;
    int n_errors, n_compared, k, n;
    ////////////////////////////////////////////////////////////////////////////
    prsu_core dut (.mclk(mclk), .rstn(rstn), .softRst(softRst), .stack_fault_reset_enable(fault),
        .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
        .liveRegs(liveRegs), .shadowOut(shadowOut), .shadowRestore(shadowRestore), .instrIn(instrIn),
        .fetchAddr(fetchAddr), .instrReg(instrReg), .flushActive(flushActive), .operandRead(operandRead),
        .resultWrite(resultWrite), .deviceResetReq(devRst));
    prsu_decoder_model partner (.fetchAddr(fetchAddr), .instrIn(instrIn), .liveRegs(liveRegs));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    // Commands only land in an open Q4 slot, so commands and register writes wait for one
    task automatic waitQ4();
        k = 0;
        while (cmdReady !== 1'b1 && k < 20) begin
            tick();
            k++;
        end
        if (k == 20) begin
            n_errors++;
            $display("ERROR %0t no command slot", $time);
        end
    endtask : waitQ4
    task automatic doCmd(prsu_pkg::prsu_op_t o, logic f, logic [19:0] t);
        waitQ4();
        pcTake = fetchAddr;
        cmdValid = 1'b1;
        cmd = '{op: o, fast: f, target: t, offset: ofs};
        tick();
        cmdValid = 1'b0;
    endtask : doCmd
    task automatic sfrW(logic [11:0] a, logic [7:0] v);
        waitQ4();
        sfrReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        tick();
        sfrReq.wr = 1'b0;
        tick();
    endtask : sfrW
    task automatic chkR(logic [11:0] a, logic [7:0] e);
        sfrReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        tick();
        sfrReq.rd = 1'b0;
        d = sfrRdata;
        `CHK(d, e)
        tick();
    endtask : chkR
    // Pulses stand one cycle, so every cycle of the window is looked at
    task automatic seePulse(ref logic p);
        n = 0;
        repeat (3) begin
            n += int'(p === 1'b1);
            tick();
        end
        `CHK(n, 1)
    endtask : seePulse
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        n_errors++;
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        softRst = 1'b0;
        fault = 1'b0;
        cmdValid = 1'b0;
        cmd = '0;
        sfrReq = '0;
        n_errors = 0;
        n_compared = 0;
        ofs = 11'h000;
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        chkR(prsu_pkg::ADDR_POINTER, 8'h00);
        doCmd(prsu_pkg::OP_CALL, 1'b0, 20'h00100);
        `CHK(fetchAddr, 21'h000200)
        `CHK(flushActive, 1'b1)
        chkR(prsu_pkg::ADDR_POINTER, 8'h01);
        chkR(prsu_pkg::ADDR_TOP_LOW, pcTake[7:0]);
        chkR(prsu_pkg::ADDR_PC_HLATCH, 8'h00);
        d = pcTake[7:0];
        doCmd(prsu_pkg::OP_RETURN, 1'b0, 20'h00000);
        `CHK(fetchAddr[7:0], d)
        chkR(prsu_pkg::ADDR_POINTER, 8'h00);
        // Saturation and underflow without fault reset; interrupts stay quiet meanwhile
        sfrW(prsu_pkg::ADDR_POINTER, 8'h1E);
        doCmd(prsu_pkg::OP_PUSH, 1'b0, 20'h00000);
        chkR(prsu_pkg::ADDR_POINTER, 8'h9F);
        sfrW(prsu_pkg::ADDR_TOP_LOW, 8'h54);
        doCmd(prsu_pkg::OP_PUSH, 1'b0, 20'h00000);
        chkR(prsu_pkg::ADDR_POINTER, 8'h9F);
        chkR(prsu_pkg::ADDR_TOP_LOW, 8'h54);
        sfrW(prsu_pkg::ADDR_POINTER, 8'h7F);
        chkR(prsu_pkg::ADDR_POINTER, 8'h1F);
        sfrW(prsu_pkg::ADDR_POINTER, 8'h00);
        doCmd(prsu_pkg::OP_POP, 1'b0, 20'h00000);
        chkR(prsu_pkg::ADDR_POINTER, 8'h40);
        doCmd(prsu_pkg::OP_RETURN, 1'b0, 20'h00000);
        `CHK(fetchAddr, 21'h000000)
        chkR(prsu_pkg::ADDR_POINTER, 8'h40);
        // Fault reset on overflow, then on underflow; a zero written to a flag clears it
        fault = 1'b1;
        sfrW(prsu_pkg::ADDR_POINTER, 8'h1E);
        doCmd(prsu_pkg::OP_CALL, 1'b0, 20'h00300);
        seePulse(devRst);
        chkR(prsu_pkg::ADDR_POINTER, 8'h80);
        sfrW(prsu_pkg::ADDR_POINTER, 8'hDF);
        chkR(prsu_pkg::ADDR_TOP_LOW, pcTake[7:0] + 8'h02);
        sfrW(prsu_pkg::ADDR_POINTER, 8'h00);
        doCmd(prsu_pkg::OP_RETURN, 1'b0, 20'h00000);
        seePulse(devRst);
        chkR(prsu_pkg::ADDR_POINTER, 8'h40);
        fault = 1'b0;
        doCmd(prsu_pkg::OP_INTACK, 1'b1, 20'h00004);
        `CHK(shadowOut, {8'h1C, 8'h5A, 8'h0E})
        doCmd(prsu_pkg::OP_RETURN_FROM_INTERRUPT, 1'b1, 20'h00000);
        seePulse(shadowRestore);
        // Program counter through its latches
        sfrW(prsu_pkg::ADDR_PC_ULATCH, 8'h03);
        sfrW(prsu_pkg::ADDR_PC_HLATCH, 8'h45);
        sfrW(prsu_pkg::ADDR_PC_LOW, 8'h67);
        `CHK(fetchAddr, 21'h034566)
        sfrW(prsu_pkg::ADDR_PC_HLATCH, 8'h00);
        // Two sequential steps since the low-byte write
        chkR(prsu_pkg::ADDR_PC_LOW, 8'h6A);
        chkR(prsu_pkg::ADDR_PC_HLATCH, 8'h45);
        doCmd(prsu_pkg::OP_JUMP, 1'b0, 20'h12345);
        `CHK(fetchAddr, 21'h02468A)
        n = 0;
        repeat (4) begin
            n += int'(cmdReady === 1'b1);
            tick();
        end
        `CHK(n, 0)
        repeat (3) tick();
        `CHK(fetchAddr, 21'h02468C)
        `CHK(instrReg, 16'h8686)
        chkR(prsu_pkg::ADDR_PC_HLATCH, 8'h45);
        seePulse(resultWrite);
        seePulse(operandRead);
        // Soft reset clears pointer, PC and fetch but keeps the flags
        doCmd(prsu_pkg::OP_PUSH, 1'b0, 20'h00000);
        softRst = 1'b1;
        tick();
        softRst = 1'b0;
        `CHK(fetchAddr, 21'h000000)
        `CHK(instrReg, 16'h0000)
        chkR(prsu_pkg::ADDR_POINTER, 8'h40);
        ofs = 11'h7FE;
        doCmd(prsu_pkg::OP_RELATIVE_CALL, 1'b0, 20'h00000);
        `CHK(fetchAddr, pcTake - 21'h000004)
        chkR(prsu_pkg::ADDR_TOP_LOW, pcTake[7:0]);
        d = pcTake[7:0];
        doCmd(prsu_pkg::OP_RETURN_WITH_LITERAL, 1'b1, 20'h00000);
        `CHK(shadowRestore, 1'b0)
        `CHK(fetchAddr[7:0], d)
        end_sim();
    end
endmodule : prsu_core_tb
